// ---- nxr_xcvr.sv ----
/*
  Transceiver side of a non-bonded channel group: shared PLL with reset
  and lock, reconfiguration busy generator, and per-channel receiver
  clock-data recovery with automatic or manual lock.
  Assumes a user reset controller drives the per-channel resets and lock
  controls synchronously to pclk, and software on APB.
*/
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/100ps

// Function
// - Every channel owns resets and frequency lock.
// - Busy pulses at power-up, then reconfiguration only.
// - Data lock control puts recovery into data.
// - PLL locks after reset, raises locked.
// - Lock control pair encodes reference, data, auto.
module nxr_xcvr
  import nxr_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [AW-1:0]       paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                pll_rst,
  output logic                     pll_locked,
  output logic                     reconfig_busy,
  input  wire nxr_chan_ctl_t [NCH-1:0] chan_ctl,
  output nxr_chan_stat_t [NCH-1:0] chan_stat
);

  logic            wr_en;
  logic            rd_en;
  logic            hit;
  logic            recfg_go_q;
  logic            short_err_q;
  logic            short_set;
  logic [CW-1:0]   pll_cnt_q;
  logic [CW-1:0]   rst_len_q;
  logic            pll_rst_q;
  logic [CW-1:0]   busy_cnt_q;
  nxr_busy_t       busy_st_q;
  logic [31:0]     stat_word;
  logic [31:0]     chan_word;

  // All checks run on pclk and sleep while reset is held
  default clocking dflt_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Zero wait state slave; unmapped offsets answer with an error
  assign pready  = 1'b1;
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & penable & ~pwrite;
  assign hit     = (paddr == CTRL_OFS) | (paddr == STAT_OFS) |
                   (paddr == CHAN_OFS);
  assign pslverr = psel & penable & ~hit;

  // Reconfiguration request: self clearing, starts one busy pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      recfg_go_q <= 1'b0;
    end else begin
      recfg_go_q <= wr_en & (paddr == CTRL_OFS) & pstrb[0] &
                    pwdata[CTRL_RECFG_BIT];
    end
  end

  // Busy: high for offset cancellation after power-up, then only on
  // a reconfiguration access. Requests during a pulse are dropped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_st_q  <= BSY_OC;
      busy_cnt_q <= '0;
    end else begin
      unique case (busy_st_q)
        BSY_OC, BSY_RECFG: begin
          if (busy_cnt_q == ((busy_st_q == BSY_OC) ? OC_CYC : RECFG_CYC) -
              CW'(1)) begin
            busy_st_q  <= BSY_IDLE;
            busy_cnt_q <= '0;
          end else begin
            busy_cnt_q <= busy_cnt_q + CW'(1);
          end
        end
        BSY_IDLE: begin
          if (recfg_go_q) begin
            busy_st_q <= BSY_RECFG;
          end
        end
        default: begin
          busy_st_q <= BSY_IDLE;
        end
      endcase
    end
  end
  assign reconfig_busy = (busy_st_q != BSY_IDLE);

  // PLL: held unlocked in reset, locks a fixed time after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_cnt_q  <= '0;
      pll_locked <= 1'b0;
    end else if (pll_rst) begin
      pll_cnt_q  <= '0;
      pll_locked <= 1'b0;
    end else if (pll_cnt_q == PLL_LOCK_CYC - CW'(1)) begin
      pll_locked <= 1'b1;
    end else begin
      pll_cnt_q  <= pll_cnt_q + CW'(1);
    end
  end

  // Reset pulse width check; a pulse under the minimum is flagged
  // because the PLL may lock to a stale reference afterwards
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_rst_q <= 1'b0;
      rst_len_q <= '0;
    end else begin
      pll_rst_q <= pll_rst;
      if (!pll_rst) begin
        rst_len_q <= '0;
      end else if (rst_len_q != PLL_RST_MIN_CYC) begin
        rst_len_q <= rst_len_q + CW'(1);
      end
    end
  end
  assign short_set = pll_rst_q & ~pll_rst & (rst_len_q < PLL_RST_MIN_CYC);

  // Sticky error; write one clears, a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      short_err_q <= 1'b0;
    end else if (short_set) begin
      short_err_q <= 1'b1;
    end else if (wr_en & (paddr == STAT_OFS) & pstrb[0] &
                 pwdata[STAT_SHORT_BIT]) begin
      short_err_q <= 1'b0;
    end
  end

  // Per-channel clock-data recovery, each reset on its own
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      nxr_cdr_t      st_q;
      logic [CW-1:0] cnt_q;
      logic          auto_m;

      // Both lock controls low selects automatic lock
      assign auto_m = ~chan_ctl[gi].lock_to_ref &
                      ~chan_ctl[gi].lock_to_data;

      // Analog reset or busy holds the channel; each channel has its own
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          st_q  <= CDR_RST;
          cnt_q <= '0;
        end else if (chan_ctl[gi].rx_ana_rst | reconfig_busy) begin
          st_q  <= CDR_RST;
          cnt_q <= '0;
        end else if (chan_ctl[gi].lock_to_data) begin
          st_q  <= CDR_LTD;
          cnt_q <= '0;
        end else if (chan_ctl[gi].lock_to_ref) begin
          st_q  <= CDR_LTR;
          cnt_q <= '0;
        end else begin
          // Automatic: train on reference, then move to data
          unique case (st_q)
            CDR_RST: begin
              st_q <= CDR_LTR;
            end
            CDR_LTR: begin
              if (cnt_q == FREQ_LOCK_CYC - CW'(1)) begin
                st_q <= CDR_LTD;
              end else begin
                cnt_q <= cnt_q + CW'(1);
              end
            end
            CDR_LTD: begin
              st_q <= CDR_LTD;
            end
            default: begin
              st_q <= CDR_RST;
            end
          endcase
        end
      end

      // Status flops; frequency lock exists only in automatic mode
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          chan_stat[gi] <= '0;
        end else begin
          chan_stat[gi].freq_locked <= auto_m & (st_q == CDR_LTD) &
                                       ~chan_ctl[gi].rx_ana_rst;
          chan_stat[gi].data_locked <= (st_q == CDR_LTD);
          chan_stat[gi].tx_ready    <= pll_locked &
                                       ~chan_ctl[gi].tx_dig_rst;
          chan_stat[gi].rx_ready    <= (st_q == CDR_LTD) &
                                       ~chan_ctl[gi].rx_dig_rst;
        end
      end

      assign chan_word[CHAN_FREQ_POS + gi] = chan_stat[gi].freq_locked;
      assign chan_word[CHAN_LTD_POS + gi]  = chan_stat[gi].data_locked;
      assign chan_word[CHAN_TXR_POS + gi]  = chan_stat[gi].tx_ready;
      assign chan_word[CHAN_RXR_POS + gi]  = chan_stat[gi].rx_ready;

      // Data lock control forces data mode one edge later
      ltd_entry_a: assert property (
        (chan_ctl[gi].lock_to_data & ~chan_ctl[gi].rx_ana_rst &
         ~reconfig_busy) |=> (st_q == CDR_LTD))
        else $error("data lock control did not enter data mode");

      // Analog reset on one channel clears its frequency lock
      chan_reset_a: assert property (
        chan_ctl[gi].rx_ana_rst |=> !chan_stat[gi].freq_locked)
        else $error("frequency lock survived channel analog reset");

      // Frequency lock reported only with both lock controls low
      mode_enc_a: assert property (
        $rose(chan_stat[gi].freq_locked) |->
          !$past(chan_ctl[gi].lock_to_ref) &&
          !$past(chan_ctl[gi].lock_to_data))
        else $error("frequency lock raised outside automatic mode");

      // Receive ready only once this channel's digital reset is gone
      rx_gate_a: assert property (
        chan_stat[gi].rx_ready |-> !$past(chan_ctl[gi].rx_dig_rst))
        else $error("receive ready under digital reset");

      // Transmit ready needs lock and this channel's own release
      tx_gate_a: assert property (
        chan_stat[gi].tx_ready |->
          $past(pll_locked) && !$past(chan_ctl[gi].tx_dig_rst))
        else $error("transmit ready without lock or release");
    end
  endgenerate
  assign chan_word[31:16] = 16'h0000;

  assign stat_word = {29'h0000_0000, short_err_q, reconfig_busy,
                      pll_locked};

  // Read data registered at the setup phase, ready for the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= RDATA_RST;
    end else if (psel & ~penable & ~pwrite) begin
      unique case (paddr)
        STAT_OFS: prdata <= stat_word;
        CHAN_OFS: prdata <= chan_word;
        default:  prdata <= RDATA_RST;
      endcase
    end
  end

  // Busy rises only from a reconfiguration request
  busy_cause_a: assert property (
    $rose(reconfig_busy) |-> $past(recfg_go_q))
    else $error("busy rose without reconfiguration access");

  // Idle busy stays low while nothing is requested
  busy_quiet_a: assert property (
    (!reconfig_busy & !recfg_go_q) |=> !reconfig_busy)
    else $error("busy rose while idle and unrequested");

  // A reconfiguration pulse lasts exactly sixteen cycles
  busy_len_a: assert property (
    $rose(reconfig_busy) |-> ##15 reconfig_busy ##1 !reconfig_busy)
    else $error("reconfiguration busy pulse has wrong length");

  // PLL reset drops lock on the next edge
  pll_unlock_a: assert property (
    pll_rst |=> !pll_locked)
    else $error("PLL stayed locked under reset");

  // Lock, once held, lasts until the next PLL reset
  pll_hold_a: assert property (
    (pll_locked & !pll_rst) |=> pll_locked)
    else $error("PLL lost lock without a reset");

  // Lock rises only after reset has been low for the lock time
  pll_lock_a: assert property (
    $rose(pll_locked) |-> !$past(pll_rst) && !$past(pll_rst, 99))
    else $error("PLL locked too soon after reset release");

  // Unmapped read answers with an error and zero data
  apb_err_a: assert property (
    (rd_en & ~hit) |-> (pslverr && prdata == RDATA_RST))
    else $error("unmapped read not flagged or not zero");

endmodule

// ---- nxr_pkg.sv ----
/*
  Shared constants and carrier types for the transceiver channel reset
  and lock model: register offsets, status field layout, cycle counts,
  and per-channel control and status structs.
  Assumes a single 250 MHz clock and an APB register bus.
*/
package nxr_pkg;

  // Channel count and bus widths
  localparam int          NCH            = 4;
  localparam int          AW             = 12;
  localparam int          CW             = 12;

  // Register byte offsets
  localparam logic [AW-1:0] CTRL_OFS     = 12'h000;
  localparam logic [AW-1:0] STAT_OFS     = 12'h004;
  localparam logic [AW-1:0] CHAN_OFS     = 12'h008;

  // Control register fields
  localparam int          CTRL_RECFG_BIT = 0;

  // Status register fields
  localparam int          STAT_LOCK_BIT  = 0;
  localparam int          STAT_BUSY_BIT  = 1;
  localparam int          STAT_SHORT_BIT = 2;

  // Channel register field positions, one nibble group per field
  localparam int          CHAN_FREQ_POS  = 0;
  localparam int          CHAN_LTD_POS   = 4;
  localparam int          CHAN_TXR_POS   = 8;
  localparam int          CHAN_RXR_POS   = 12;

  // Clock and timing
  localparam int          CLK_PERIOD_PS  = 4000;
  localparam int          PLL_RST_MIN_NS = 1;
  localparam int          PLL_RST_MIN_US = 1;
  localparam logic [CW-1:0] PLL_RST_MIN_CYC = CW'(
    (PLL_RST_MIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  // Model cycle counts for the analog behaviour
  localparam logic [CW-1:0] OC_CYC        = 12'h040;
  localparam logic [CW-1:0] RECFG_CYC     = 12'h010;
  localparam logic [CW-1:0] PLL_LOCK_CYC  = 12'h064;
  localparam logic [CW-1:0] FREQ_LOCK_CYC = 12'h0C8;

  // Reset values
  localparam logic [31:0] RDATA_RST      = 32'h0000_0000;

  // Per-channel controls driven by the reset controller
  typedef struct packed {
    logic tx_dig_rst;
    logic rx_ana_rst;
    logic rx_dig_rst;
    logic lock_to_ref;
    logic lock_to_data;
  } nxr_chan_ctl_t;

  // Per-channel status returned to the controller
  typedef struct packed {
    logic freq_locked;
    logic data_locked;
    logic tx_ready;
    logic rx_ready;
  } nxr_chan_stat_t;

  // Receiver clock-data recovery state
  typedef enum logic [2:0] {
    CDR_RST = 3'b001,
    CDR_LTR = 3'b010,
    CDR_LTD = 3'b100
  } nxr_cdr_t;

  // Reconfiguration busy generator state
  typedef enum logic [2:0] {
    BSY_OC    = 3'b001,
    BSY_IDLE  = 3'b010,
    BSY_RECFG = 3'b100
  } nxr_busy_t;

endpackage

// ---- nxr_rst_ctl.sv ----
/*
  Behavioural user reset controller for the channel group: one PLL reset
  pulse and per-channel transmit, receive and lock-mode sequencing.
  Assumes the transceiver runs on pclk and the bench picks each mode.
*/
`timescale 1ns/100ps
module nxr_rst_ctl
  import nxr_pkg::*;
#(
  parameter int LTD_AUTO = 20,
  parameter int SW_WAIT  = 30,
  parameter int LTD_MAN  = 25
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic [CW-1:0]            pll_w,
  input  wire logic [NCH-1:0]           tx_en,
  input  wire logic [NCH-1:0]           rx_en,
  input  wire logic [NCH-1:0]           man,
  input  wire logic                     pll_locked,
  input  wire logic                     reconfig_busy,
  input  wire nxr_chan_stat_t [NCH-1:0] chan_stat,
  output logic                          pll_rst,
  output nxr_chan_ctl_t [NCH-1:0]       chan_ctl
);
  logic [CW-1:0] pcnt_q;
  logic [1:0]    bcnt_q;

  // PLL reset pulse of pll_w cycles; a short width is allowed on purpose
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pcnt_q <= '0;
    else if (pll_rst) pcnt_q <= pcnt_q + CW'(1);
  end
  assign pll_rst = (pcnt_q < pll_w);

  // Cycles since busy fell, saturating at two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) bcnt_q <= '0;
    else if (reconfig_busy) bcnt_q <= '0;
    else if (bcnt_q != 2'h2) bcnt_q <= bcnt_q + 2'h1;
  end

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic          tx_q, ana_q, dig_q, ltd_q, run;
    logic [CW-1:0] cnt_q, tgt;
    // Wait counter runs only once its trigger holds; in automatic mode loss of frequency lock restarts it
    assign run = !ana_q && dig_q && (man[i] || chan_stat[i].freq_locked);
    assign tgt = CW'(man[i] ? (ltd_q ? LTD_MAN : SW_WAIT) : LTD_AUTO);
    // Releases are sticky: a later busy pulse does not restart the channel
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        tx_q  <= 1'h1;
        ana_q <= 1'h1;
        dig_q <= 1'h1;
        ltd_q <= 1'h0;
        cnt_q <= '0;
      end else begin
        if (tx_en[i] && !pll_rst && pll_locked)
          tx_q <= 1'h0;
        if (rx_en[i] && !pll_rst && bcnt_q == 2'h2)
          ana_q <= 1'h0;
        if (!run) cnt_q <= '0;
        else if (cnt_q != tgt) cnt_q <= cnt_q + CW'(1);
        else if (man[i] && !ltd_q) begin
          ltd_q <= 1'h1;
          cnt_q <= '0;
        end else dig_q <= 1'h0;
      end
    end
    assign chan_ctl[i] = '{tx_q, ana_q, dig_q, man[i] & ~ltd_q,
                           ltd_q};
  end
endmodule

// ---- test_nxr_xcvr.sv ----
/*
  Self-checking bench for the transceiver channel group, with the model
  reset controller on the channel side and an APB master on the bus.
  Assumes the zero-wait bus and the model cycle counts of the package.
*/
`timescale 1ns/100ps
module test_nxr_xcvr
  import nxr_pkg::*;
;
  logic                     pclk, presetn, psel, penable, pwrite, pready;
  logic                     pslverr, pll_rst, pll_locked, reconfig_busy, er;
  logic [AW-1:0]            paddr;
  logic [31:0]              pwdata, prdata, rd;
  logic [3:0]               pstrb;
  logic [CW-1:0]            pll_w;
  logic [NCH-1:0]           tx_en, rx_en, man;
  nxr_chan_ctl_t [NCH-1:0]  chan_ctl;
  nxr_chan_stat_t [NCH-1:0] chan_stat;
  int                       n_fail, num_checks, n;

  nxr_xcvr dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pll_rst(pll_rst), .pll_locked(pll_locked),
    .reconfig_busy(reconfig_busy), .chan_ctl(chan_ctl),
    .chan_stat(chan_stat));
  nxr_rst_ctl ctl (.pclk(pclk), .presetn(presetn), .pll_w(pll_w),
    .tx_en(tx_en), .rx_en(rx_en), .man(man), .pll_locked(pll_locked),
    .reconfig_busy(reconfig_busy), .chan_stat(chan_stat),
    .pll_rst(pll_rst), .chan_ctl(chan_ctl));

  // 250 MHz clock
  always #2 pclk = ~pclk;

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // One APB transfer; the request holds until pready is seen high
  task automatic apb(input logic w, input logic [AW-1:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int k = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 50);
    if (pready !== 1'h1) begin
      n_fail++;
      test_done();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // Watched levels: busy, lock, PLL reset, channel 0 transmit ready and channels 1 to 3 receive ready
  function automatic logic sig(input int s);
    case (s)
      0: return reconfig_busy;
      1: return pll_locked;
      2: return pll_rst;
      default: return chan_stat[0].tx_ready & chan_stat[1].rx_ready &
                      chan_stat[2].rx_ready & chan_stat[3].rx_ready;
    endcase
  endfunction

  // Bounded wait, returning the number of edges it took
  task automatic wfor(input int s, input logic v, output int c);
    c = 0;
    while (sig(s) !== v) begin
      @(posedge pclk);
      c++;
      if (c > 3000) begin
        n_fail++;
        test_done();
      end
    end
  endtask

  // Reset for 10 cycles with a PLL pulse width and channel three's mode
  task automatic boot(input logic [CW-1:0] w, input logic m3);
    presetn <= 1'h0;
    pll_w <= w;
    man <= {m3, 3'h4};
    repeat (10) @(posedge pclk);
    chk("busy_rst", reconfig_busy, 1'h1);
    chk("lock_rst", pll_locked, 1'h0);
    presetn <= 1'h1;
  endtask

  // Pass 0: tx-only, rx auto, rx manual, combined auto, full PLL pulse.
  // Pass 1: channel three combined manual with a too-short PLL pulse.
  initial begin
    pclk = 1'h0;
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hF;
    pll_w = '0;
    tx_en = 4'h9;
    rx_en = 4'hE;
    man = '0;
    n_fail = 0;
    num_checks = 0;
    for (int p = 0; p < 2; p++) begin
      boot(p ? 12'h014 : 12'h0FA, p[0]);
      if (p == 0) begin
        wfor(0, 1'h0, n);
        chk("busy_len", 32'(n >= 63 && n <= 66), 32'h1);
      end
      wfor(2, 1'h0, n);
      wfor(1, 1'h1, n);
      chk("lock_time", 32'(n >= 99 && n <= 102), 32'h1);
      wfor(3, 1'h1, n);
      apb(1'h0, CHAN_OFS, 32'h0, rd, er);
      chk("chan", rd, p ? 32'hE9E2 : 32'hE9EA);
      apb(1'h0, STAT_OFS, 32'h0, rd, er);
      chk("stat", rd, p ? 32'h5 : 32'h1);
      chk("stat_err", er, 1'h0);
      if (p) begin
        apb(1'h1, STAT_OFS, 32'h4, rd, er);
        apb(1'h0, STAT_OFS, 32'h0, rd, er);
        chk("stat_clr", rd, 32'h1);
      end else begin
        chk("busy_idle", reconfig_busy, 1'h0);
        apb(1'h0, CTRL_OFS, 32'h0, rd, er);
        chk("ctrl", rd, 32'h0);
        apb(1'h0, 12'h00C, 32'h0, rd, er);
        chk("unmapped_data", rd, 32'h0);
        chk("unmapped_err", er, 1'h1);
        apb(1'h1, CTRL_OFS, 32'h1, rd, er);
        wfor(0, 1'h1, n);
        chk("busy_start", 32'(n >= 1 && n <= 3), 32'h1);
        wfor(0, 1'h0, n);
        chk("busy_pulse", 32'(n >= 15 && n <= 17), 32'h1);
        repeat (50) @(posedge pclk);
        chk("busy_after", reconfig_busy, 1'h0);
      end
    end
    test_done();
  end
endmodule
